//--- src/serial_rx_pkg.sv
// Purpose: Shared constants and types of the asynchronous serial receiver
// Assumes: Register indices times four give AXI4-Lite byte addresses
// Notes: Only the receive path and its register view are modelled
package serial_rx_pkg;
    // Register indices; byte address is the index times four
    localparam logic [7:0] IDX_GLOBAL_IRQ = 8'h0b;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_RX_CTRL = 8'h18;
    localparam logic [7:0] IDX_RX_DATA = 8'h1a;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h8c;
    localparam logic [7:0] IDX_TX_CTRL = 8'h98;
    localparam logic [7:0] IDX_BAUD = 8'h99;
    localparam int ADDR_W = 12;

    // Field positions
    localparam int GLOBAL_IE_BIT = 7;
    localparam int PERIPH_IE_BIT = 6;
    localparam int RX_FLAG_BIT = 5;
    localparam int RX_IE_BIT = 5;
    localparam int PORT_EN_BIT = 7;
    localparam int NINTH_EN_BIT = 6;
    localparam int CONT_EN_BIT = 4;
    localparam int ADDR_EN_BIT = 3;
    localparam int FRAME_ERR_BIT = 2;
    localparam int OVERRUN_BIT = 1;
    localparam int NINTH_VAL_BIT = 0;
    localparam int MODE_SYNC_BIT = 4;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int SHIFT_EMPTY_BIT = 1;

    // Write masks and reset values
    localparam logic [7:0] RX_CTRL_WMASK = 8'hf8;
    localparam logic [7:0] IRQ_ENABLE_WMASK = 8'h7f;
    localparam logic [7:0] TX_CTRL_WMASK = 8'hf5;
    localparam logic [7:0] TX_CTRL_RESET = 8'h02;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Oversampling: 16 samples per bit, majority of samples 7, 8 and 9
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [3:0] SAMPLE_LAST = 4'hf;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [3:0] BITS_EIGHT = 4'h7;
    localparam logic [3:0] BITS_NINE = 4'h8;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

    typedef struct packed {
        logic frame_err;
        logic ninth;
        logic [7:0] data;
    } rx_entry_t;
endpackage

//--- src/sample_tick_gen.sv
// Purpose: Oversampling tick at sixteen times the bit rate
// Assumes: Divisor counts clk periods per base tick, minus one
// Notes: Low-speed setting divides the base tick by four (x64 base)
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic high_speed,
    input wire logic [7:0] divisor,
    output logic tick
);
    logic [7:0] div_cnt;
    logic [1:0] pre_cnt;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= 8'h00;
            pre_cnt <= 2'h0;
            tick <= 1'b0;
        end else if (!run) begin
            div_cnt <= 8'h00;
            pre_cnt <= 2'h0;
            tick <= 1'b0;
        end else if (div_cnt == divisor) begin
            div_cnt <= 8'h00;
            pre_cnt <= 2'(pre_cnt + 2'h1);
            tick <= high_speed || (pre_cnt == serial_rx_pkg::PRESCALE_LAST);
        end else begin
            div_cnt <= 8'(div_cnt + 8'h01);
            tick <= 1'b0;
        end
    end
endmodule // sample_tick_gen
`default_nettype wire

//--- src/async_serial_receiver.sv
// Purpose: Asynchronous serial receiver with two-entry buffer and AXI4-Lite registers
// Assumes: Line idles high; 100 MHz clk; sys_rst asynchronous, active high
// Notes: Transmitter and synchronous modes are absent; synchronous select stops reception, high-speed bit sets sample rate, the other transmitter bits only store
// Contract
// - Recover bits at x16, shift at bit rate
// - Accept frames only while continuous enable set
// - Stop bit moves word to buffer, sets flag
// - Receive flag read-only, clears when buffer empty
// - Interrupt only while receive interrupt enabled
// - Two-entry buffer, words read in order
// - Full buffer at stop: overrun, drop word
// - Overrun cleared only by toggling continuous enable
// - Overrun blocks all transfers into buffer
// - Low stop bit sets framing error
// - Framing and ninth bit stored per entry
// - Ninth-bit enable captures nine data bits
// - Address-match enable turns on address detection in nine-bit mode only
// - Address-match cleared: all words loaded, interrupt
// - Clearing continuous enable clears error conditions
// - Start, 8/9 data LSB first, one stop
// - Sample clock x16 or x64 by speed bit
// - Asynchronous mode when synchronous select clear
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module async_serial_receiver (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic receive_line_pin,
    output logic rx_irq,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic majority3(input logic a, input logic b, input logic c);
        majority3 = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic mapped(input logic [11:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        mapped = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
                 (idx == serial_rx_pkg::IDX_GLOBAL_IRQ || idx == serial_rx_pkg::IDX_IRQ_FLAGS ||
                  idx == serial_rx_pkg::IDX_RX_CTRL || idx == serial_rx_pkg::IDX_RX_DATA ||
                  idx == serial_rx_pkg::IDX_IRQ_ENABLE || idx == serial_rx_pkg::IDX_TX_CTRL ||
                  idx == serial_rx_pkg::IDX_BAUD);
    endfunction

    // Software registers
    logic [7:0] global_interrupt_control;
    logic [7:0] peripheral_irq_enable;
    logic [7:0] rx_ctrl;
    logic [7:0] transmit_control_status;
    logic [7:0] baud_divisor;
    logic overrun_error;

    // Buffer
    serial_rx_pkg::rx_entry_t fifo_mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] fifo_count;
    serial_rx_pkg::rx_entry_t head;
    logic receive_flag;

    // Line and frame state
    logic line_meta;
    logic line_sync;
    logic line_prev;
    logic sample_tick;
    serial_rx_pkg::rx_state_t state;
    logic [3:0] sub_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] samples;
    logic [8:0] receive_shifter;
    logic frame_done;
    logic [7:0] done_data;
    logic done_ninth;
    logic done_framing_error;

    // Bus state
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic next_aw_held;
    logic next_w_held;
    logic next_rvalid;
    logic do_write;
    logic ar_hs;
    logic data_pop;

    logic cont_en;
    logic ninth_en;
    logic addr_en;
    logic rx_on;
    logic fifo_full;
    logic addr_drop;
    logic push;
    logic bit_val;

    assign cont_en = rx_ctrl[serial_rx_pkg::CONT_EN_BIT];
    assign ninth_en = rx_ctrl[serial_rx_pkg::NINTH_EN_BIT];
    assign addr_en = rx_ctrl[serial_rx_pkg::ADDR_EN_BIT];
    assign rx_on = rx_ctrl[serial_rx_pkg::PORT_EN_BIT] && cont_en &&
                   !transmit_control_status[serial_rx_pkg::MODE_SYNC_BIT];
    assign head = fifo_mem[rd_ptr];
    assign receive_flag = (fifo_count != 2'h0);
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign data_pop = ar_hs && mapped(s_axi_araddr) && receive_flag &&
                      (s_axi_araddr[9:2] == serial_rx_pkg::IDX_RX_DATA);
    assign fifo_full = (fifo_count == serial_rx_pkg::FIFO_DEPTH) && !data_pop;
    assign addr_drop = addr_en && ninth_en && !done_ninth;
    assign push = frame_done && rx_on && !overrun_error && !fifo_full && !addr_drop;
    assign bit_val = majority3(samples[1], samples[0], line_sync);

    // Two flip-flops ahead of any logic on the line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
            line_prev <= 1'b1;
        end else begin
            line_meta <= receive_line_pin;
            line_sync <= line_meta;
            line_prev <= line_sync;
        end
    end

    sample_tick_gen tick_gen (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(rx_on),
        .high_speed(transmit_control_status[serial_rx_pkg::HIGH_SPEED_BIT]),
        .divisor(baud_divisor),
        .tick(sample_tick)
    );

    // Frame recovery: sixteen ticks per bit, one shift per bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= serial_rx_pkg::RX_IDLE;
            sub_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            samples <= 2'h0;
            receive_shifter <= 9'h000;
            frame_done <= 1'b0;
            done_data <= 8'h00;
            done_ninth <= 1'b0;
            done_framing_error <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (!rx_on) begin
                state <= serial_rx_pkg::RX_IDLE;
                sub_cnt <= 4'h0;
            end else if (state == serial_rx_pkg::RX_IDLE) begin
                if (line_prev && !line_sync) begin
                    state <= serial_rx_pkg::RX_START;
                    sub_cnt <= 4'h0;
                    bit_cnt <= 4'h0;
                end
            end else if (sample_tick) begin
                sub_cnt <= 4'(sub_cnt + 4'h1);
                if (sub_cnt == serial_rx_pkg::SAMPLE_A || sub_cnt == serial_rx_pkg::SAMPLE_B) begin
                    samples <= {samples[0], line_sync};
                end
                case (state)
                    serial_rx_pkg::RX_START: begin
                        if (sub_cnt == serial_rx_pkg::SAMPLE_C && bit_val) begin
                            state <= serial_rx_pkg::RX_IDLE;
                        end else if (sub_cnt == serial_rx_pkg::SAMPLE_LAST) begin
                            state <= serial_rx_pkg::RX_DATA;
                        end
                    end
                    serial_rx_pkg::RX_DATA: begin
                        if (sub_cnt == serial_rx_pkg::SAMPLE_C) begin
                            receive_shifter <= {bit_val, receive_shifter[8:1]};
                        end
                        if (sub_cnt == serial_rx_pkg::SAMPLE_LAST) begin
                            bit_cnt <= 4'(bit_cnt + 4'h1);
                            if (bit_cnt == (ninth_en ? serial_rx_pkg::BITS_NINE
                                                     : serial_rx_pkg::BITS_EIGHT)) begin
                                state <= serial_rx_pkg::RX_STOP;
                            end
                        end
                    end
                    serial_rx_pkg::RX_STOP: begin
                        if (sub_cnt == serial_rx_pkg::SAMPLE_C) begin
                            // Finish at stop centre so the next start edge is seen
                            state <= serial_rx_pkg::RX_IDLE;
                            frame_done <= 1'b1;
                            done_framing_error <= !bit_val;
                            done_data <= ninth_en ? receive_shifter[7:0] : receive_shifter[8:1];
                            done_ninth <= ninth_en && receive_shifter[8];
                        end
                    end
                    default: begin
                        state <= serial_rx_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Buffer: two entries in arrival order
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fifo_count <= 2'h0;
        end else begin
            if (push) begin
                fifo_mem[wr_ptr] <= '{frame_err: done_framing_error, ninth: done_ninth, data: done_data};
                wr_ptr <= !wr_ptr;
            end
            if (!cont_en) begin
                // Clearing the enable also clears stored framing errors
                fifo_mem[0].frame_err <= 1'b0;
                fifo_mem[1].frame_err <= 1'b0;
            end
            if (data_pop) begin
                rd_ptr <= !rd_ptr;
            end
            fifo_count <= 2'(fifo_count + {1'b0, push} - {1'b0, data_pop});
        end
    end

    // Overrun: set on a full buffer at stop, cleared only by dropping the enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            overrun_error <= 1'b0;
        end else if (!cont_en) begin
            overrun_error <= 1'b0;
        end else if (frame_done && rx_on && fifo_full) begin
            overrun_error <= 1'b1;
        end
    end

    // Interrupt request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= receive_flag && peripheral_irq_enable[serial_rx_pkg::RX_IE_BIT] &&
                      global_interrupt_control[serial_rx_pkg::PERIPH_IE_BIT] &&
                      global_interrupt_control[serial_rx_pkg::GLOBAL_IE_BIT];
        end
    end

    // Write channel
    always_comb begin
        do_write = aw_held && w_held && !s_axi_bvalid;
        next_aw_held = (aw_held && !do_write) || (s_axi_awvalid && s_axi_awready);
        next_w_held = (w_held && !do_write) || (s_axi_wvalid && s_axi_wready);
        next_rvalid = (s_axi_rvalid && !s_axi_rready) || ar_hs;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= serial_rx_pkg::RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= !next_aw_held;
            s_axi_wready <= !next_w_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr) ? serial_rx_pkg::RESP_OKAY : serial_rx_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; only byte lane 0 carries data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            global_interrupt_control <= serial_rx_pkg::ZERO_BYTE;
            peripheral_irq_enable <= serial_rx_pkg::ZERO_BYTE;
            rx_ctrl <= serial_rx_pkg::ZERO_BYTE;
            transmit_control_status <= serial_rx_pkg::TX_CTRL_RESET;
            baud_divisor <= serial_rx_pkg::ZERO_BYTE;
        end else if (do_write && w_lane && mapped(aw_addr)) begin
            case (aw_addr[9:2])
                serial_rx_pkg::IDX_GLOBAL_IRQ: global_interrupt_control <= w_byte;
                serial_rx_pkg::IDX_IRQ_ENABLE: peripheral_irq_enable <= w_byte & serial_rx_pkg::IRQ_ENABLE_WMASK;
                serial_rx_pkg::IDX_RX_CTRL: rx_ctrl <= w_byte & serial_rx_pkg::RX_CTRL_WMASK;
                serial_rx_pkg::IDX_TX_CTRL: transmit_control_status <=
                    (w_byte & serial_rx_pkg::TX_CTRL_WMASK) | serial_rx_pkg::TX_CTRL_RESET;
                serial_rx_pkg::IDX_BAUD: baud_divisor <= w_byte;
                default: begin
                end
            endcase
        end
    end

    // Read channel; reading the data register pops the buffer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= serial_rx_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_hs) begin
                s_axi_rresp <= mapped(s_axi_araddr) ? serial_rx_pkg::RESP_OKAY : serial_rx_pkg::RESP_SLVERR;
                s_axi_rdata <= 32'h00000000;
                case (s_axi_araddr[9:2])
                    serial_rx_pkg::IDX_GLOBAL_IRQ: s_axi_rdata[7:0] <= global_interrupt_control;
                    serial_rx_pkg::IDX_IRQ_FLAGS: s_axi_rdata[serial_rx_pkg::RX_FLAG_BIT] <= receive_flag;
                    serial_rx_pkg::IDX_RX_CTRL: s_axi_rdata[7:0] <= rx_ctrl |
                        {5'h00, head.frame_err && receive_flag, overrun_error,
                         head.ninth && receive_flag};
                    serial_rx_pkg::IDX_RX_DATA: s_axi_rdata[7:0] <= head.data;
                    serial_rx_pkg::IDX_IRQ_ENABLE: s_axi_rdata[7:0] <= peripheral_irq_enable;
                    serial_rx_pkg::IDX_TX_CTRL: s_axi_rdata[7:0] <= transmit_control_status;
                    serial_rx_pkg::IDX_BAUD: s_axi_rdata[7:0] <= baud_divisor;
                    default: begin
                    end
                endcase
                if (!mapped(s_axi_araddr)) begin
                    s_axi_rdata <= 32'h00000000;
                end
            end
        end
    end

    a_irq_needs_enable: assert property (@(posedge clk) disable iff (sys_rst)
        !peripheral_irq_enable[serial_rx_pkg::RX_IE_BIT] |=> !rx_irq)
        else $error("interrupt raised while receive interrupt disabled");
    a_flag_follows_fill: assert property (@(posedge clk) disable iff (sys_rst)
        push |=> receive_flag && (fifo_count > $past(fifo_count) ||
                                  ($past(data_pop) && fifo_count == $past(fifo_count))))
        else $error("receive flag not set after buffer load");
    a_buffer_bound: assert property (@(posedge clk) disable iff (sys_rst)
        fifo_count <= serial_rx_pkg::FIFO_DEPTH)
        else $error("buffer holds more than two words");
    a_overrun_sets: assert property (@(posedge clk) disable iff (sys_rst)
        (frame_done && rx_on && fifo_count == 2'h2 && !data_pop) |=> (overrun_error || !cont_en))
        else $error("overrun not flagged on full buffer");
    a_overrun_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        overrun_error |=> fifo_count <= $past(fifo_count))
        else $error("buffer loaded during overrun");
    a_enable_clears: assert property (@(posedge clk) disable iff (sys_rst)
        !cont_en |=> !overrun_error && !head.frame_err)
        else $error("errors survive cleared continuous enable");
    a_disabled_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !rx_on |=> state == serial_rx_pkg::RX_IDLE ##1 !frame_done)
        else $error("receiver active while disabled");
    a_address_drop: assert property (@(posedge clk) disable iff (sys_rst)
        (frame_done && addr_en && ninth_en && !done_ninth) |=> fifo_count <= $past(fifo_count))
        else $error("non-address word loaded in address mode");
    a_stop_error: assert property (@(posedge clk) disable iff (sys_rst)
        (state == serial_rx_pkg::RX_STOP && sample_tick && sub_cnt == serial_rx_pkg::SAMPLE_C && rx_on &&
         !bit_val) |=> frame_done && done_framing_error)
        else $error("low stop bit did not flag framing error");
endmodule // async_serial_receiver
`default_nettype wire

//--- bench/serial_line_model.sv
// Purpose: Remote asynchronous transmitter driving the receive line
// Assumes: Bit time is bt clk: 16 at high speed, 64 at low speed, divisor 0
// Notes: Line idles high between frames; gap sets idle bits after a frame
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
    input wire logic clk,
    output logic line
);
    int bt = 16;
    initial line = 1'b1;
    task automatic send(input logic [8:0] w, input logic nine, input logic stop, input int gap);
        int n;
        n = nine ? 9 : 8;
        line <= 1'b0;
        repeat (bt) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            line <= w[i];
            repeat (bt) @(posedge clk);
        end
        line <= stop;
        repeat (bt) @(posedge clk);
        // A low stop bit needs a gap, or the next start bit has no falling edge
        if (gap > 0) begin
            line <= 1'b1;
            repeat (bt * gap) @(posedge clk);
        end
    endtask
endmodule // serial_line_model
`default_nettype wire

//--- bench/tb_async_serial_receiver.sv
// Purpose: Self-checking bench for the asynchronous serial receiver
// Assumes: Reads note expected {rresp, data} in a queue that a monitor drains
// Notes: Random words come from a 16-bit shift register sequence
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_receiver;
    localparam logic [7:0] CTRL = serial_rx_pkg::IDX_RX_CTRL;
    localparam logic [7:0] DATA = serial_rx_pkg::IDX_RX_DATA;
    localparam logic [7:0] FLG = serial_rx_pkg::IDX_IRQ_FLAGS;
    localparam logic [7:0] IEN = serial_rx_pkg::IDX_IRQ_ENABLE;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic line, irq, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [9:0] exp_q[$];
    logic [15:0] rnd = 16'h953b;
    logic [8:0] q[4];
    int fail_count = 0, samples_checked = 0, cyc = 0;

    serial_line_model i_tx (.clk(clk), .line(line));
    async_serial_receiver i_dut (.clk(clk), .sys_rst(sys_rst), .receive_line_pin(line), .rx_irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    always #5 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task check(input logic [9:0] seen, input logic [9:0] want);
        samples_checked++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [9:0] want);
        @(posedge clk);
        exp_q.push_back(want);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // Watches read answers and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rvalid && rready) check({rresp, rdata[7:0]}, exp_q.pop_front());
        if (cyc == 20000) begin
            fail_count++;
            wrap_up;
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(serial_rx_pkg::IDX_TX_CTRL, 10'h002);
        rd(8'h01, 10'h200);
        wr(serial_rx_pkg::IDX_BAUD, 8'h00);
        wr(serial_rx_pkg::IDX_TX_CTRL, 8'h04);
        wr(IEN, 8'h20);
        wr(serial_rx_pkg::IDX_GLOBAL_IRQ, 8'hc0);
        wr(CTRL, 8'h80);
        i_tx.send(9'h0a5, 1'b0, 1'b1, 1);
        rd(FLG, 10'h000);
        wr(CTRL, 8'h90);
        $display("setup test done");
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            q[i] = {1'b0, rnd[7:0]};
        end
        i_tx.send(q[0], 1'b0, 1'b0, 1);
        i_tx.send(q[1], 1'b0, 1'b1, 1);
        check({9'h0, irq}, 10'h001);
        wr(IEN, 8'h00);
        repeat (3) @(posedge clk);
        check({9'h0, irq}, 10'h000);
        wr(IEN, 8'h20);
        rd(CTRL, 10'h094);
        rd(DATA, {2'h0, q[0][7:0]});
        rd(CTRL, 10'h090);
        rd(DATA, {2'h0, q[1][7:0]});
        rd(FLG, 10'h000);
        check({9'h0, irq}, 10'h000);
        $display("framing test done");
        for (int i = 0; i < 4; i++) i_tx.send(q[i], 1'b0, 1'b1, 0);
        rd(CTRL, 10'h092);
        rd(DATA, {2'h0, q[0][7:0]});
        rd(DATA, {2'h0, q[1][7:0]});
        rd(FLG, 10'h000);
        wr(CTRL, 8'h80);
        wr(CTRL, 8'h90);
        rd(CTRL, 10'h090);
        i_tx.send(q[2], 1'b0, 1'b1, 2);
        rd(DATA, {2'h0, q[2][7:0]});
        wr(serial_rx_pkg::IDX_TX_CTRL, 8'h00);
        rd(serial_rx_pkg::IDX_TX_CTRL, 10'h002);
        i_tx.bt = 64;
        i_tx.send(q[3], 1'b0, 1'b1, 1);
        rd(DATA, {2'h0, q[3][7:0]});
        i_tx.bt = 16;
        wr(serial_rx_pkg::IDX_TX_CTRL, 8'h04);
        $display("overrun test done");
        wr(CTRL, 8'hd8);
        i_tx.send(9'h033, 1'b1, 1'b1, 0);
        i_tx.send({1'b1, q[3][7:0]}, 1'b1, 1'b1, 1);
        rd(CTRL, 10'h0d9);
        rd(DATA, {2'h0, q[3][7:0]});
        rd(FLG, 10'h000);
        wr(CTRL, 8'hd0);
        i_tx.send({1'b0, q[1][7:0]}, 1'b1, 1'b1, 1);
        rd(FLG, 10'h020);
        rd(CTRL, 10'h0d0);
        rd(DATA, {2'h0, q[1][7:0]});
        $display("address test done");
        wrap_up;
    end
endmodule // tb_async_serial_receiver
`default_nettype wire
